//--- exec_core.sv
// Instruction executor for logic, rotate, bit, skip, branch and save/restore operations
// Notes on behaviour
// - XOR accumulator with memory or immediate
// - Swap nibbles of memory operand
// - Rotate memory operand through carry flag
// - Clear or set one selected bit
// - Compare sets zero and carry, skip if equal
// - Increment/decrement to accumulator, skip on zero
// - In-place increment/decrement, skip on zero
// - Skip next when selected bit clear
// - Skip next when selected bit set
// - Jump loads page bits and target, two cycles
// - Call pushes program counter plus one, then jumps
// - Returns pop counter; interrupt return re-enables interrupts
// - Save accumulator and flags except status bits
// - Restore accumulator and flags, status bits untouched
// - RAM write-back costs one extra cycle
// - Taken skip costs one extra cycle
`timescale 1ns/1ps
`default_nettype none
module exec_core
    import exec_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Instruction issue
    input wire logic instr_valid,
    input wire op_e instr_op,
    input wire logic [7:0] instr_addr,
    input wire logic [7:0] instr_imm,
    input wire logic [2:0] instr_bit,
    input wire logic instr_bank0,
    input wire logic [13:0] instr_target,
    // Operand read data and context
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] bank_select,
    input wire logic [1:0] rom_page_select_bits,
    input wire logic [15:0] stack_top,
    // Instruction accept
    output logic instr_ready,
    // Operand memory
    output logic [15:0] mem_addr,
    output logic mem_we,
    output logic [7:0] mem_wdata,
    // Stack
    output logic stack_push,
    output logic stack_pop,
    output logic [15:0] stack_wdata,
    // Architectural state
    output logic [15:0] pc,
    output logic [7:0] accumulator_reg,
    output logic [7:0] program_flag_register,
    output logic global_int_enable,
    output logic skip_pending,
    output logic [1:0] last_cycles
);
    typedef enum logic [1:0] {st_idle, st_wait} state_e;

    typedef struct packed {
        state_e state;
        logic [1:0] wait_cnt;
        logic skip;
        logic [15:0] pc;
        logic [7:0] acc;
        logic [7:0] flags;
        logic [7:0] save_acc;
        logic [7:0] save_flags;
        logic gie;
        logic ready;
        logic [15:0] mem_addr;
        logic mem_we;
        logic [7:0] mem_wdata;
        logic push;
        logic pop;
        logic [15:0] push_data;
        logic [1:0] cycles;
    } core_s;

    core_s r;
    core_s next_r;

    logic [7:0] alu_result;
    logic alu_carry;
    logic alu_bit;
    logic writes_mem;
    logic to_acc;
    logic is_sysreg;
    logic skip_cond;
    logic [1:0] cost;
    logic [7:0] bank_eff;
    logic exec;

    // Operand datapath
    exec_alu u_alu (
        .op(instr_op),
        .acc(r.acc),
        .mem(mem_rdata),
        .imm(instr_imm),
        .bit_sel(instr_bit),
        .carry_in(r.flags[FLAG_C]),
        .result(alu_result),
        .carry_out(alu_carry),
        .sel_bit(alu_bit)
    );

    // Cycle accounting
    exec_cycles u_cycles (
        .op(instr_op),
        .writes_mem(writes_mem),
        .is_sysreg(is_sysreg),
        .skip_taken(skip_cond),
        .cycles(cost)
    );

    // Bank-zero forms ignore the current bank
    assign bank_eff = instr_bank0 ? 8'h00 : bank_select;
    // System registers sit in the top half of bank 0
    assign is_sysreg = (bank_eff == 8'h00) && (instr_addr >= SYSREG_BASE);
    assign exec = instr_valid && r.ready;

    // Destination class of each operation
    always_comb begin
        writes_mem = 1'b0;
        to_acc = 1'b0;
        case (instr_op)
            op_or_ma, op_xor_ma, op_nibble_exchange_in_place,
            op_rotate_right_carry_in_place, op_rotate_left_carry_in_place,
            op_clr, op_bit_clear, op_bit_set,
            op_increment_skip_zero_in_place, op_decrement_skip_zero_in_place:
                writes_mem = 1'b1;
            op_or_am, op_or_ai, op_xor_am, op_xor_ai, op_swap,
            op_rotate_right_carry_to_acc, op_rotate_left_carry_to_acc,
            op_increment_skip_zero_to_acc, op_decrement_skip_zero_to_acc:
                to_acc = 1'b1;
            default: begin
                writes_mem = 1'b0;
                to_acc = 1'b0;
            end
        endcase
    end

    // Skip conditions, evaluated on the operation's own result
    always_comb begin
        case (instr_op)
            op_compare_skip_equal_i, op_compare_skip_equal_m:
                skip_cond = (alu_result == 8'h00);
            op_increment_skip_zero_to_acc, op_decrement_skip_zero_to_acc:
                skip_cond = (alu_result == 8'h00);
            op_increment_skip_zero_in_place, op_decrement_skip_zero_in_place:
                skip_cond = (alu_result == 8'h00);
            op_bit_test_skip_clear: skip_cond = !alu_bit;
            op_bit_test_skip_set: skip_cond = alu_bit;
            default: skip_cond = 1'b0;
        endcase
    end

    // Next-state: one instruction taken per idle cycle, then wait out its cost
    always_comb begin
        next_r = r;
        next_r.mem_we = 1'b0;
        next_r.push = 1'b0;
        next_r.pop = 1'b0;
        case (r.state)
            st_idle: begin
                if (exec && r.skip) begin
                    // Shadowed instruction: only the counter moves
                    next_r.skip = 1'b0;
                    next_r.pc = r.pc + 16'h0001;
                    next_r.cycles = CYC_BASE;
                end else if (exec) begin
                    next_r.pc = r.pc + 16'h0001;
                    next_r.cycles = cost;
                    next_r.skip = skip_cond;
                    if (to_acc) begin
                        next_r.acc = alu_result;
                    end
                    if (writes_mem) begin
                        next_r.mem_we = 1'b1;
                        next_r.mem_addr = {bank_eff, instr_addr};
                        next_r.mem_wdata = alu_result;
                    end
                    // Zero flag on logic results, carry on rotates, both on compares; then branches and save/restore
                    case (instr_op)
                        op_or_am, op_or_ma, op_or_ai, op_xor_am, op_xor_ma, op_xor_ai:
                            next_r.flags[FLAG_Z] = (alu_result == 8'h00);
                        op_rotate_right_carry_to_acc, op_rotate_right_carry_in_place,
                        op_rotate_left_carry_to_acc, op_rotate_left_carry_in_place:
                            next_r.flags[FLAG_C] = alu_carry;
                        op_compare_skip_equal_i, op_compare_skip_equal_m: begin
                            next_r.flags[FLAG_Z] = (alu_result == 8'h00);
                            next_r.flags[FLAG_C] = alu_carry;
                        end
                        op_jump: begin
                            next_r.pc = {rom_page_select_bits, instr_target};
                        end
                        op_call: begin
                            next_r.push = 1'b1;
                            next_r.push_data = r.pc + 16'h0001;
                            next_r.pc = {rom_page_select_bits, instr_target};
                        end
                        op_ret: begin
                            next_r.pop = 1'b1;
                            next_r.pc = stack_top;
                        end
                        op_return_from_interrupt: begin
                            next_r.pop = 1'b1;
                            next_r.pc = stack_top;
                            next_r.gie = 1'b1;
                        end
                        op_save: begin
                            next_r.save_acc = r.acc;
                            next_r.save_flags = r.flags & SAVE_MASK;
                        end
                        op_restore: begin
                            next_r.acc = r.save_acc;
                            next_r.flags = (r.flags & ~SAVE_MASK)
                                | (r.save_flags & SAVE_MASK);
                        end
                        default: next_r.flags = next_r.flags;
                    endcase
                    // Multi-cycle ops hold off the next issue
                    if (cost > CYC_BASE) begin
                        next_r.state = st_wait;
                        next_r.wait_cnt = cost - 2'h1;
                        next_r.ready = 1'b0;
                    end
                end
            end
            st_wait: begin
                // Extra cycles for write-back, skip or branch
                next_r.wait_cnt = r.wait_cnt - 2'h1;
                if (r.wait_cnt == 2'h1) begin
                    next_r.state = st_idle;
                    next_r.ready = 1'b1;
                end
            end
            default: begin
                next_r.state = st_idle;
                next_r.ready = 1'b1;
            end
        endcase
    end

    // Single state register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            r.state <= st_idle;
            r.wait_cnt <= 2'h0;
            r.skip <= 1'b0;
            r.pc <= RESET_PC;
            r.acc <= RESET_ACC;
            r.flags <= RESET_FLAGS;
            r.save_acc <= RESET_ACC;
            r.save_flags <= RESET_FLAGS;
            r.gie <= 1'b0;
            r.ready <= 1'b1;
            r.mem_addr <= 16'h0000;
            r.mem_we <= 1'b0;
            r.mem_wdata <= 8'h00;
            r.push <= 1'b0;
            r.pop <= 1'b0;
            r.push_data <= 16'h0000;
            r.cycles <= 2'h0;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign instr_ready = r.ready;
    assign mem_addr = r.mem_addr;
    assign mem_we = r.mem_we;
    assign mem_wdata = r.mem_wdata;
    assign stack_push = r.push;
    assign stack_pop = r.pop;
    assign stack_wdata = r.push_data;
    assign pc = r.pc;
    assign accumulator_reg = r.acc;
    assign program_flag_register = r.flags;
    assign global_int_enable = r.gie;
    assign skip_pending = r.skip;
    assign last_cycles = r.cycles;
endmodule
`default_nettype wire

//--- exec_pkg.sv
// Package: opcode set, widths, flag positions and cycle figures for the executor
package exec_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 16;
    localparam int ADDR_W = 8;
    localparam int TARGET_W = 14;
    // Flag register positions
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_NPD = 6;
    localparam int FLAG_NTO = 7;
    // Bits covered by save and restore
    localparam logic [7:0] SAVE_MASK = 8'h3f;
    // Bank 0 addresses from here up are system registers (no write-back cycle)
    localparam logic [7:0] SYSREG_LIMIT = 8'h80;
    localparam logic [7:0] SYSREG_BASE = 8'h80;
    localparam logic [7:0] RESET_ACC = 8'h00;
    localparam logic [7:0] RESET_FLAGS = 8'h00;
    localparam logic [15:0] RESET_PC = 16'h0000;
    // Cycle figures
    localparam logic [1:0] CYC_BASE = 2'h1;
    localparam logic [1:0] CYC_BRANCH = 2'h2;
    // Operations
    typedef enum logic [4:0] {
        op_nop, op_or_am, op_or_ma, op_or_ai, op_xor_am, op_xor_ma, op_xor_ai,
        op_swap, op_nibble_exchange_in_place,
        op_rotate_right_carry_to_acc, op_rotate_right_carry_in_place,
        op_rotate_left_carry_to_acc, op_rotate_left_carry_in_place,
        op_clr, op_bit_clear, op_bit_set,
        op_compare_skip_equal_i, op_compare_skip_equal_m,
        op_increment_skip_zero_to_acc, op_increment_skip_zero_in_place,
        op_decrement_skip_zero_to_acc, op_decrement_skip_zero_in_place,
        op_bit_test_skip_clear, op_bit_test_skip_set,
        op_jump, op_call, op_ret, op_return_from_interrupt, op_save, op_restore
    } op_e;
endpackage

//--- exec_alu.sv
// Combinational data path for the logic, rotate, bit and count operations
`timescale 1ns/1ps
`default_nettype none
module exec_alu
    import exec_pkg::*;
(
    // Operation and operands
    input wire op_e op,
    input wire logic [7:0] acc,
    input wire logic [7:0] mem,
    input wire logic [7:0] imm,
    input wire logic [2:0] bit_sel,
    input wire logic carry_in,
    // Results
    output logic [7:0] result,
    output logic carry_out,
    output logic sel_bit
);
    logic [8:0] diff;
    // One result bus, routed to acc or memory by the caller
    always_comb begin
        result = mem;
        carry_out = carry_in;
        sel_bit = mem[bit_sel];
        diff = 9'h000;
        case (op)
            op_or_am, op_or_ma: result = acc | mem;
            op_or_ai: result = acc | imm;
            op_xor_am, op_xor_ma: result = acc ^ mem;
            op_xor_ai: result = acc ^ imm;
            op_swap, op_nibble_exchange_in_place: result = {mem[3:0], mem[7:4]};
            op_rotate_right_carry_to_acc, op_rotate_right_carry_in_place: begin
                result = {carry_in, mem[7:1]};
                carry_out = mem[0];
            end
            op_rotate_left_carry_to_acc, op_rotate_left_carry_in_place: begin
                result = {mem[6:0], carry_in};
                carry_out = mem[7];
            end
            op_clr: result = 8'h00;
            op_bit_clear: result = mem & ~(8'h01 << bit_sel);
            op_bit_set: result = mem | (8'h01 << bit_sel);
            op_compare_skip_equal_i, op_compare_skip_equal_m: begin
                // Carry set means no borrow
                diff = {1'b0, acc} - {1'b0, (op == op_compare_skip_equal_i) ? imm : mem};
                result = diff[7:0];
                carry_out = ~diff[8];
            end
            op_increment_skip_zero_to_acc, op_increment_skip_zero_in_place:
                result = mem + 8'h01;
            op_decrement_skip_zero_to_acc, op_decrement_skip_zero_in_place:
                result = mem - 8'h01;
            default: result = mem;
        endcase
    end
endmodule
`default_nettype wire

//--- exec_cycles.sv
// Cycle cost of one instruction from write-back and skip outcome
`timescale 1ns/1ps
`default_nettype none
module exec_cycles
    import exec_pkg::*;
(
    // Instruction class
    input wire op_e op,
    input wire logic writes_mem,
    input wire logic is_sysreg,
    input wire logic skip_taken,
    // Cost in cycles
    output logic [1:0] cycles
);
    // Branches are a flat two; everything else is 1 plus N plus S
    always_comb begin
        case (op)
            op_jump, op_call, op_ret, op_return_from_interrupt:
                cycles = CYC_BRANCH;
            default: begin
                cycles = CYC_BASE;
                if (writes_mem && !is_sysreg) begin
                    cycles = cycles + 2'h1;
                end
                if (skip_taken) begin
                    cycles = cycles + 2'h1;
                end
            end
        endcase
    end
endmodule
`default_nettype wire

//--- exec_core_asserts.sv
// Checker: port-level timing and result relations of the executor
`timescale 1ns/1ps
`default_nettype none
module exec_core_asserts
    import exec_pkg::*;
(
    // Clock, reset and issue
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic instr_valid,
    input wire op_e instr_op,
    input wire logic [7:0] instr_addr,
    input wire logic [7:0] instr_imm,
    input wire logic instr_bank0,
    input wire logic [7:0] bank_select,
    input wire logic [13:0] instr_target,
    input wire logic [1:0] rom_page_select_bits,
    input wire logic [15:0] stack_top,
    // Observed outputs
    input wire logic instr_ready,
    input wire logic mem_we,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic [15:0] stack_wdata,
    input wire logic [15:0] pc,
    input wire logic [7:0] accumulator_reg,
    input wire logic [7:0] program_flag_register,
    input wire logic global_int_enable,
    input wire logic skip_pending,
    input wire logic [1:0] last_cycles
);
    logic take;
    logic sysreg;
    // Accepted and not discarded by a pending skip
    assign take = instr_valid && instr_ready && !skip_pending;
    assign sysreg = (instr_bank0 || bank_select == 8'h00) && instr_addr >= SYSREG_LIMIT;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    chk_jump_target: assert property (
        take && instr_op == op_jump |=> pc == {$past(rom_page_select_bits), $past(instr_target)})
        else $error("jump target wrong");
    chk_jump_stall: assert property (
        take && instr_op == op_jump |=> !instr_ready ##1 instr_ready)
        else $error("jump stall wrong");
    chk_call_push: assert property (
        take && instr_op == op_call |=> stack_push && stack_wdata == $past(pc) + 16'h1)
        else $error("call push wrong");
    chk_return_from_interrupt_enable: assert property (
        take && instr_op == op_return_from_interrupt
        |=> stack_pop && global_int_enable && pc == $past(stack_top))
        else $error("interrupt return wrong");
    chk_skip_discard: assert property (
        instr_valid && instr_ready && skip_pending
        |=> pc == $past(pc) + 16'h1 && !mem_we && $stable(accumulator_reg))
        else $error("skipped word executed");
    chk_sysreg_cost: assert property (
        take && instr_op == op_xor_ma && sysreg |=> mem_we && last_cycles == 2'h1 && instr_ready)
        else $error("system register cost wrong");
    chk_ram_cost: assert property (
        take && instr_op == op_xor_ma && !sysreg |=> mem_we && last_cycles == 2'h2 ##1 !mem_we)
        else $error("ram write cost wrong");
    chk_restore_status: assert property (
        take && instr_op == op_restore
        |=> (program_flag_register & 8'hc0) == ($past(program_flag_register) & 8'hc0)
        && last_cycles == 2'h1 && instr_ready)
        else $error("status bits touched");
    chk_xor_imm: assert property (
        take && instr_op == op_xor_ai
        |=> accumulator_reg == ($past(accumulator_reg) ^ $past(instr_imm)))
        else $error("xor result wrong");
    chk_nop_quiet: assert property (
        take && instr_op == op_nop |=> $stable(accumulator_reg)
        && $stable(program_flag_register) && !mem_we && last_cycles == 2'h1)
        else $error("nop changed state");
    // Main scenarios reached
    cov_skip: cover property (skip_pending && instr_valid && instr_ready);
    cov_call: cover property (stack_push);
    cov_return_from_interrupt: cover property (take && instr_op == op_return_from_interrupt);
endmodule
bind exec_core exec_core_asserts u_chk (.clk_sys, .rstn, .instr_valid, .instr_op, .instr_addr,
    .instr_imm, .instr_bank0, .bank_select, .instr_target, .rom_page_select_bits, .stack_top,
    .instr_ready, .mem_we, .stack_push, .stack_pop, .stack_wdata, .pc, .accumulator_reg,
    .program_flag_register, .global_int_enable, .skip_pending, .last_cycles);
`default_nettype wire

//--- cpu_logic_branch_instr_exec_tb.sv
// Testbench: drives the executor directly and checks results per operation
`timescale 1ns/1ps
`default_nettype none
module cpu_logic_branch_instr_exec_tb;
    import exec_pkg::*;
    logic clk_sys, rstn, instr_valid, instr_bank0, instr_ready, mem_we, stack_push, stack_pop;
    logic global_int_enable, skip_pending;
    op_e instr_op;
    logic [7:0] instr_addr, instr_imm, mem_rdata, bank_select, mem_wdata, acc, flags;
    logic [2:0] instr_bit;
    logic [13:0] instr_target;
    logic [1:0] rom_page_select_bits, last_cycles;
    logic [15:0] stack_top, mem_addr, stack_wdata, pc;
    int errors = 0;
    int checked = 0;
    exec_core dut (.clk_sys(clk_sys), .rstn(rstn), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_addr(instr_addr), .instr_imm(instr_imm),
        .instr_bit(instr_bit), .instr_bank0(instr_bank0), .instr_target(instr_target),
        .mem_rdata(mem_rdata), .bank_select(bank_select),
        .rom_page_select_bits(rom_page_select_bits), .stack_top(stack_top),
        .instr_ready(instr_ready), .mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata),
        .stack_push(stack_push), .stack_pop(stack_pop), .stack_wdata(stack_wdata), .pc(pc),
        .accumulator_reg(acc), .program_flag_register(flags),
        .global_int_enable(global_int_enable), .skip_pending(skip_pending),
        .last_cycles(last_cycles));
    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One instruction, offered until taken; results land one edge later
    task automatic issue(input op_e op, input logic [7:0] ad, input logic [7:0] rd,
        input logic [7:0] im, input logic [2:0] bn);
        int n;
        n = 0;
        while (instr_ready !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("ready", instr_ready, 1'b1);
        instr_op = op;
        instr_addr = ad;
        mem_rdata = rd;
        instr_imm = im;
        instr_bit = bn;
        instr_valid = 1'b1;
        @(posedge clk_sys);
        #1;
        instr_valid = 1'b0;
        mem_rdata = ~rd;
    endtask
    task automatic lk(input logic [7:0] ea, input logic [1:0] ec, input logic es);
        check("acc", acc, ea);
        check("cycles", last_cycles, ec);
        check("skip", skip_pending, es);
    endtask
    task automatic wr(input logic [15:0] ea, input logic [7:0] ed);
        check("we", mem_we, 1'b1);
        check("waddr", mem_addr, ea);
        check("wdata", mem_wdata, ed);
    endtask
    task automatic t_logic;
        issue(op_xor_ai, 8'h00, 8'h00, 8'h5a, 3'h0);
        lk(8'h5a, 2'h1, 1'b0);
        issue(op_xor_am, 8'h10, 8'hff, 8'h00, 3'h0);
        lk(8'ha5, 2'h1, 1'b0);
        issue(op_xor_ma, 8'h10, 8'h0f, 8'h00, 3'h0);
        wr(16'h0010, 8'haa);
        lk(8'ha5, 2'h2, 1'b0);
        issue(op_xor_ma, 8'h85, 8'h0f, 8'h00, 3'h0);
        lk(8'ha5, 2'h1, 1'b0);
        issue(op_xor_ai, 8'h00, 8'h00, 8'ha5, 3'h0);
        lk(8'h00, 2'h1, 1'b0);
        check("zf", flags[FLAG_Z], 1'b1);
        // OR and clear also write back; RAM costs one more, system register none
        issue(op_or_ma, 8'h10, 8'h0f, 8'h00, 3'h0);
        wr(16'h0010, 8'h0f);
        check("cycles", last_cycles, 2'h2);
        issue(op_clr, 8'h85, 8'h3c, 8'h00, 3'h0);
        wr(16'h0085, 8'h00);
        check("cycles", last_cycles, 2'h1);
        $display("test logic done");
    endtask
    task automatic t_shift;
        issue(op_swap, 8'h20, 8'h3c, 8'h00, 3'h0);
        lk(8'hc3, 2'h1, 1'b0);
        issue(op_nibble_exchange_in_place, 8'h20, 8'h12, 8'h00, 3'h0);
        wr(16'h0020, 8'h21);
        issue(op_compare_skip_equal_i, 8'h00, 8'h00, 8'h00, 3'h0);
        lk(8'hc3, 2'h1, 1'b0);
        check("zc", flags & 8'h05, 8'h01);
        issue(op_rotate_right_carry_to_acc, 8'h20, 8'h02, 8'h00, 3'h0);
        lk(8'h81, 2'h1, 1'b0);
        issue(op_rotate_left_carry_in_place, 8'h20, 8'h80, 8'h00, 3'h0);
        wr(16'h0020, 8'h00);
        check("cf", flags[FLAG_C], 1'b1);
        issue(op_rotate_left_carry_to_acc, 8'h20, 8'h01, 8'h00, 3'h0);
        lk(8'h03, 2'h1, 1'b0);
        issue(op_rotate_right_carry_in_place, 8'h20, 8'h01, 8'h00, 3'h0);
        wr(16'h0020, 8'h00);
        check("cf", flags[FLAG_C], 1'b1);
        $display("test shift done");
    endtask
    task automatic t_bits;
        bank_select = 8'h01;
        issue(op_bit_set, 8'h30, 8'h00, 8'h00, 3'h3);
        wr(16'h0130, 8'h08);
        check("cycles", last_cycles, 2'h2);
        instr_bank0 = 1'b1;
        issue(op_bit_clear, 8'h30, 8'hff, 8'h00, 3'h7);
        wr(16'h0030, 8'h7f);
        instr_bank0 = 1'b0;
        bank_select = 8'h00;
        $display("test bits done");
    endtask
    task automatic t_skips;
        issue(op_compare_skip_equal_i, 8'h00, 8'h00, 8'h03, 3'h0);
        lk(8'h03, 2'h2, 1'b1);
        check("zc", flags & 8'h05, 8'h05);
        issue(op_xor_ai, 8'h00, 8'h00, 8'hff, 3'h0);
        lk(8'h03, 2'h1, 1'b0);
        issue(op_increment_skip_zero_to_acc, 8'h40, 8'hff, 8'h00, 3'h0);
        lk(8'h00, 2'h2, 1'b1);
        check("zc", flags & 8'h05, 8'h05);
        issue(op_nop, 8'h00, 8'h00, 8'h00, 3'h0);
        lk(8'h00, 2'h1, 1'b0);
        issue(op_decrement_skip_zero_in_place, 8'h40, 8'h01, 8'h00, 3'h0);
        wr(16'h0040, 8'h00);
        lk(8'h00, 2'h3, 1'b1);
        issue(op_xor_ma, 8'h40, 8'h55, 8'h00, 3'h0);
        check("we", mem_we, 1'b0);
        issue(op_decrement_skip_zero_to_acc, 8'h40, 8'h05, 8'h00, 3'h0);
        lk(8'h04, 2'h1, 1'b0);
        issue(op_increment_skip_zero_in_place, 8'h40, 8'h05, 8'h00, 3'h0);
        wr(16'h0040, 8'h06);
        lk(8'h04, 2'h2, 1'b0);
        issue(op_bit_test_skip_clear, 8'h40, 8'hfb, 8'h00, 3'h2);
        lk(8'h04, 2'h2, 1'b1);
        issue(op_nop, 8'h00, 8'h00, 8'h00, 3'h0);
        issue(op_bit_test_skip_set, 8'h40, 8'hfb, 8'h00, 3'h2);
        lk(8'h04, 2'h1, 1'b0);
        issue(op_bit_test_skip_set, 8'h40, 8'h04, 8'h00, 3'h2);
        lk(8'h04, 2'h2, 1'b1);
        issue(op_nop, 8'h00, 8'h00, 8'h00, 3'h0);
        issue(op_bit_test_skip_clear, 8'h40, 8'h04, 8'h00, 3'h2);
        lk(8'h04, 2'h1, 1'b0);
        issue(op_compare_skip_equal_m, 8'h40, 8'h04, 8'h00, 3'h0);
        lk(8'h04, 2'h2, 1'b1);
        issue(op_nop, 8'h00, 8'h00, 8'h00, 3'h0);
        $display("test skips done");
    endtask
    task automatic t_branch;
        rom_page_select_bits = 2'h2;
        instr_target = 14'h1234;
        issue(op_jump, 8'h00, 8'h00, 8'h00, 3'h0);
        check("pc", pc, 16'h9234);
        check("cycles", last_cycles, 2'h2);
        issue(op_nop, 8'h00, 8'h00, 8'h00, 3'h0);
        check("pc", pc, 16'h9235);
        lk(8'h04, 2'h1, 1'b0);
        rom_page_select_bits = 2'h1;
        instr_target = 14'h0100;
        issue(op_call, 8'h00, 8'h00, 8'h00, 3'h0);
        check("pc", pc, 16'h4100);
        check("push", stack_push, 1'b1);
        check("ret addr", stack_wdata, 16'h9236);
        stack_top = 16'h9236;
        issue(op_ret, 8'h00, 8'h00, 8'h00, 3'h0);
        check("pc", pc, 16'h9236);
        check("pop", stack_pop, 1'b1);
        check("gie", global_int_enable, 1'b0);
        stack_top = 16'h1000;
        issue(op_return_from_interrupt, 8'h00, 8'h00, 8'h00, 3'h0);
        check("pc", pc, 16'h1000);
        check("gie", global_int_enable, 1'b1);
        $display("test branch done");
    endtask
    task automatic t_save;
        issue(op_save, 8'h00, 8'h00, 8'h00, 3'h0);
        lk(8'h04, 2'h1, 1'b0);
        issue(op_compare_skip_equal_i, 8'h00, 8'h00, 8'hff, 3'h0);
        check("zc", flags, 8'h00);
        issue(op_xor_ai, 8'h00, 8'h00, 8'h10, 3'h0);
        lk(8'h14, 2'h1, 1'b0);
        issue(op_restore, 8'h00, 8'h00, 8'h00, 3'h0);
        lk(8'h04, 2'h1, 1'b0);
        check("flags", flags & SAVE_MASK, 8'h05);
        $display("test save done");
    endtask
    task automatic give_verdict;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Cuts a hang short; the whole run needs well under 1000 cycles
    initial begin
        #50000;
        errors++;
        give_verdict();
    end
    // Reset, then the scenarios in order
    initial begin
        {rstn, instr_valid, instr_bank0} = 3'b000;
        {instr_addr, instr_imm, mem_rdata, bank_select} = 32'h0;
        {instr_bit, rom_page_select_bits} = 5'h0;
        instr_op = op_nop;
        instr_target = 14'h0;
        stack_top = 16'h0;
        repeat (20) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        t_logic();
        t_shift();
        t_bits();
        t_skips();
        t_branch();
        t_save();
        give_verdict();
    end
endmodule
`default_nettype wire
